// File: rtl/fsps_pkg.sv
// Shared constants for the flash self-programming sequencer.
// Assumes a 32-bit AXI4-Lite register bus and an 8-bit flash array port.
package fsps_pkg;
    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam logic [7:0] FSPS_OFF_CMD = 8'h00;
    localparam logic [7:0] FSPS_OFF_APH = 8'h04;
    localparam logic [7:0] FSPS_OFF_APL = 8'h08;
    localparam logic [7:0] FSPS_OFF_APHC = 8'h0c;
    localparam logic [7:0] FSPS_OFF_APLC = 8'h10;
    localparam logic [7:0] FSPS_OFF_WBUF = 8'h14;
    localparam logic [7:0] FSPS_OFF_STAT = 8'h18;
    localparam logic [7:0] FSPS_OFF_WATCHDOG_ENABLE_REG = 8'h1c;
    localparam logic [7:0] FSPS_OFF_PROT = 8'h20;
    localparam logic [7:0] FSPS_OFF_MODE = 8'h24;
    localparam logic [7:0] FSPS_OFF_HALT = 8'h28;
    localparam logic [7:0] FSPS_OFF_WDCNT = 8'h2c;
    // ************************************************************
    // Codes and fields
    // ************************************************************
    localparam logic [7:0] FSPS_CMD_ERASE = 8'h03;
    localparam logic [7:0] FSPS_CMD_BLANK = 8'h04;
    localparam logic [7:0] FSPS_CMD_WRITE = 8'h05;
    localparam logic [7:0] FSPS_WDT_KEY = 8'hac;
    localparam logic [7:0] FSPS_PROT_KEY = 8'ha5;
    localparam logic [7:0] FSPS_ERASED = 8'hff;
    localparam logic [7:0] FSPS_ZERO8 = 8'h00;
    localparam int FSPS_BIT_SEQ = 0;
    localparam int FSPS_BIT_VC = 1;
    localparam int FSPS_BIT_WEP = 2;
    localparam logic [1:0] FSPS_RESP_OKAY = 2'b00;
    localparam logic [1:0] FSPS_RESP_SLVERR = 2'b10;
    localparam logic [31:0] FSPS_RDATA_ZERO = 32'h0000_0000;
    typedef enum logic [2:0] {
        FSPS_IDLE, FSPS_RUN, FSPS_WAIT, FSPS_NEXT, FSPS_DONE
    } fsps_state_t;
endpackage

// File: rtl/fsps_if.sv
// Register-side signals passed between the bus slave and the sequencer core.
// Assumes both ends run on the same clock.
interface fsps_if;
    logic wr_stb;
    logic rd_stb;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [31:0] rdata;
    logic err;
    modport slave (output wr_stb, rd_stb, addr, wdata, input rdata, err);
    modport core (input wr_stb, rd_stb, addr, wdata, output rdata, err);
endinterface

// File: rtl/fsps_axil_slave.sv
// AXI4-Lite slave front end: turns bus transfers into one-cycle strobes.
// Assumes a synchronous core that returns read data combinationally.
module fsps_axil_slave
    import fsps_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    fsps_if.slave reg_if
);
    logic aw_held_q;
    logic w_held_q;
    logic [7:0] aw_q;
    logic [7:0] w_q;
    logic w_lane_q;
    logic wr_go;
    logic rd_go;

    assign wr_go = aw_held_q && w_held_q && !bvalid;
    assign rd_go = arvalid && arready;
    // Read goes first when both collide on the same cycle
    assign reg_if.wr_stb = clk_en && wr_go && w_lane_q && !rd_go;
    assign reg_if.rd_stb = clk_en && rd_go;
    assign reg_if.addr = rd_go ? araddr : aw_q;
    assign reg_if.wdata = w_q;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            aw_q <= FSPS_ZERO8;
            w_q <= FSPS_ZERO8;
            w_lane_q <= 1'b0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= FSPS_RESP_OKAY;
        end
        else if (clk_en)
        begin
            awready <= !aw_held_q && !awready;
            wready <= !w_held_q && !wready;
            if (awvalid && awready)
            begin
                aw_held_q <= 1'b1;
                aw_q <= awaddr;
                awready <= 1'b0;
            end
            if (wvalid && wready)
            begin
                w_held_q <= 1'b1;
                w_q <= wdata[7:0];
                w_lane_q <= wstrb[0];
                wready <= 1'b0;
            end
            if (wr_go && !rd_go)
            begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                bvalid <= 1'b1;
                bresp <= reg_if.err ? FSPS_RESP_SLVERR : FSPS_RESP_OKAY;
            end
            else if (bvalid && bready)
                bvalid <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= FSPS_RDATA_ZERO;
            rresp <= FSPS_RESP_OKAY;
        end
        else if (clk_en)
        begin
            arready <= !rvalid && !arready;
            if (rd_go)
            begin
                arready <= 1'b0;
                rvalid <= 1'b1;
                rdata <= reg_if.rdata;
                rresp <= reg_if.err ? FSPS_RESP_SLVERR : FSPS_RESP_OKAY;
            end
            else if (rvalid && rready)
                rvalid <= 1'b0;
        end
    end
endmodule

// File: rtl/fsps_top.sv
// Flash self-programming sequencer: registers, mode unlock, erase/blank/write.
// Assumes an 8-bit flash array that answers one access per ack pulse.
// Function
// - Command code 03h selects block erase for the next run.
// - Command code 04h selects block blank check for the next run.
// - Command code 05h selects single byte write for the next run.
// - Byte write programs the write buffer value at the address.
// - Writing ACh to watchdog enable clears and restarts the watchdog.
// - Halt starts the operation; CPU resumes after halt on completion.
// - Bit 1 flags verify/compare error, bit 2 protect error.
// - Status zero after a run means normal, nonzero means abnormal.
// - Mode entry needs A5h then 01h, FEh, 01h; only last write counts.
// - A broken unlock sequence sets bit 0 and leaves mode unchanged; here a write to a register other than MODE aborts it without setting bit 0.
//
// Our own choices: the AXI4-Lite register port and the address map.
module fsps_top
    import fsps_pkg::*;
#(
    parameter int WDT_W = 16,
    parameter int WDT_LIMIT = 50000
)
(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic [7:0] s_axil_awaddr,
    input wire logic s_axil_awvalid,
    output logic s_axil_awready,
    input wire logic [31:0] s_axil_wdata,
    input wire logic [3:0] s_axil_wstrb,
    input wire logic s_axil_wvalid,
    output logic s_axil_wready,
    output logic [1:0] s_axil_bresp,
    output logic s_axil_bvalid,
    input wire logic s_axil_bready,
    input wire logic [7:0] s_axil_araddr,
    input wire logic s_axil_arvalid,
    output logic s_axil_arready,
    output logic [31:0] s_axil_rdata,
    output logic [1:0] s_axil_rresp,
    output logic s_axil_rvalid,
    input wire logic s_axil_rready,
    output logic cpu_halted_q,
    output logic self_prog_mode_q,
    output logic wdt_overflow_q,
    output logic flash_req_q,
    output logic flash_we_q,
    output logic flash_erase_q,
    output logic [15:0] flash_addr_q,
    output logic [7:0] flash_wdata_q,
    input wire logic flash_ack,
    input wire logic [7:0] flash_rdata,
    input wire logic flash_prot_err
);
    // ************************************************************
    // Reset release
    // ************************************************************
    logic rst_meta_q;
    logic rst_n_q;
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    fsps_if reg_if ();

    fsps_axil_slave u_slave (
        .clk(sys_clk),
        .rst_n(rst_n_q),
        .clk_en(clk_en),
        .awaddr(s_axil_awaddr),
        .awvalid(s_axil_awvalid),
        .awready(s_axil_awready),
        .wdata(s_axil_wdata),
        .wstrb(s_axil_wstrb),
        .wvalid(s_axil_wvalid),
        .wready(s_axil_wready),
        .bresp(s_axil_bresp),
        .bvalid(s_axil_bvalid),
        .bready(s_axil_bready),
        .araddr(s_axil_araddr),
        .arvalid(s_axil_arvalid),
        .arready(s_axil_arready),
        .rdata(s_axil_rdata),
        .rresp(s_axil_rresp),
        .rvalid(s_axil_rvalid),
        .rready(s_axil_rready),
        .reg_if(reg_if)
    );

    // ************************************************************
    // Registers
    // ************************************************************
    logic [7:0] cmd_q, aph_q, apl_q, aphc_q, aplc_q, wbuf_q;
    logic [2:0] stat_q;
    logic [7:0] cur_q;
    logic [1:0] unlock_q;
    logic [7:0] unlock_val_q;
    fsps_state_t state_q;
    logic busy;
    logic wr, rd;
    logic [7:0] wa, wd;
    logic vc_set, wep_set, seq_set;
    logic [WDT_W-1:0] wdt_q;

    assign busy = (state_q != FSPS_IDLE);
    assign wr = reg_if.wr_stb;
    assign rd = reg_if.rd_stb;
    assign wa = reg_if.addr;
    assign wd = reg_if.wdata;

    // Operand writes are dropped while a run is active
    always_ff @(posedge sys_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            cmd_q <= FSPS_ZERO8;
            aph_q <= FSPS_ZERO8;
            apl_q <= FSPS_ZERO8;
            aphc_q <= FSPS_ZERO8;
            aplc_q <= FSPS_ZERO8;
            wbuf_q <= FSPS_ZERO8;
        end
        else if (clk_en && wr && !busy)
        begin
            case (wa)
                FSPS_OFF_CMD: cmd_q <= wd;
                FSPS_OFF_APH: aph_q <= wd;
                FSPS_OFF_APL: apl_q <= wd;
                FSPS_OFF_APHC: aphc_q <= wd;
                FSPS_OFF_APLC: aplc_q <= wd;
                FSPS_OFF_WBUF: wbuf_q <= wd;
                default: ;
            endcase
        end
    end

    always_comb
    begin
        reg_if.err = 1'b0;
        case (wa)
            FSPS_OFF_CMD: reg_if.rdata = {24'h000000, cmd_q};
            FSPS_OFF_APH: reg_if.rdata = {24'h000000, aph_q};
            FSPS_OFF_APL: reg_if.rdata = {24'h000000, apl_q};
            FSPS_OFF_APHC: reg_if.rdata = {24'h000000, aphc_q};
            FSPS_OFF_APLC: reg_if.rdata = {24'h000000, aplc_q};
            FSPS_OFF_WBUF: reg_if.rdata = {24'h000000, wbuf_q};
            FSPS_OFF_STAT: reg_if.rdata = {29'h0000000, stat_q};
            FSPS_OFF_MODE: reg_if.rdata = {31'h0000000, self_prog_mode_q};
            FSPS_OFF_HALT: reg_if.rdata = {31'h0000000, cpu_halted_q};
            FSPS_OFF_WDCNT: reg_if.rdata = {{(32-WDT_W){1'b0}}, wdt_q};
            FSPS_OFF_WATCHDOG_ENABLE_REG, FSPS_OFF_PROT: reg_if.rdata = FSPS_RDATA_ZERO;
            default:
            begin
                reg_if.rdata = FSPS_RDATA_ZERO;
                reg_if.err = 1'b1;
            end
        endcase
    end

    // ************************************************************
    // Status flags: a hardware set beats a software clear
    // ************************************************************
    always_ff @(posedge sys_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
            stat_q <= 3'h0;
        else if (clk_en)
        begin
            if (wr && wa == FSPS_OFF_STAT)
                stat_q <= wd[2:0] | {wep_set, vc_set, seq_set};
            else
            begin
                if (seq_set) stat_q[FSPS_BIT_SEQ] <= 1'b1;
                if (vc_set) stat_q[FSPS_BIT_VC] <= 1'b1;
                if (wep_set) stat_q[FSPS_BIT_WEP] <= 1'b1;
            end
        end
    end

    // ************************************************************
    // Protected mode change
    // ************************************************************
    // Step 0 idle, 1 after key, 2 after value, 3 after inverse
    always_ff @(posedge sys_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            unlock_q <= 2'd0;
            unlock_val_q <= FSPS_ZERO8;
            self_prog_mode_q <= 1'b0;
        end
        else if (clk_en && wr && !busy)
        begin
            if (wa == FSPS_OFF_PROT)
                unlock_q <= (wd == FSPS_PROT_KEY) ? 2'd1 : 2'd0;
            else if (wa == FSPS_OFF_MODE)
            begin
                case (unlock_q)
                    2'd1:
                    begin
                        unlock_val_q <= wd;
                        unlock_q <= 2'd2;
                    end
                    2'd2: unlock_q <= (wd == ~unlock_val_q) ? 2'd3 : 2'd0;
                    2'd3:
                    begin
                        if (wd == unlock_val_q)
                            self_prog_mode_q <= wd[0];
                        unlock_q <= 2'd0;
                    end
                    default: unlock_q <= 2'd0;
                endcase
            end
            else
                unlock_q <= 2'd0;
        end
    end

    always_comb
    begin
        seq_set = 1'b0;
        if (wr && !busy && wa == FSPS_OFF_MODE)
        begin
            case (unlock_q)
                2'd0: seq_set = 1'b1;
                2'd2: seq_set = (wd != ~unlock_val_q);
                2'd3: seq_set = (wd != unlock_val_q);
                default: seq_set = 1'b0;
            endcase
        end
    end

    // ************************************************************
    // Watchdog
    // ************************************************************
    always_ff @(posedge sys_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            wdt_q <= '0;
            wdt_overflow_q <= 1'b0;
        end
        else if (clk_en)
        begin
            if (wr && wa == FSPS_OFF_WATCHDOG_ENABLE_REG && wd == FSPS_WDT_KEY)
            begin
                wdt_q <= '0;
                wdt_overflow_q <= 1'b0;
            end
            else if (wdt_q == WDT_W'(WDT_LIMIT - 1))
                wdt_overflow_q <= 1'b1;
            else
                wdt_q <= wdt_q + 1'b1;
        end
    end

    // ************************************************************
    // Sequencer
    // ************************************************************
    logic legal;
    logic is_erase, is_blank, is_write;
    assign is_erase = (cmd_q == FSPS_CMD_ERASE);
    assign is_blank = (cmd_q == FSPS_CMD_BLANK);
    assign is_write = (cmd_q == FSPS_CMD_WRITE);
    // Bad operands end the run at once as a compare error
    assign legal = (is_write) || ((is_erase || is_blank) && aphc_q == aph_q
        && apl_q == FSPS_ZERO8 && aplc_q == (is_erase ? FSPS_ZERO8 : FSPS_ERASED));
    assign vc_set = (state_q == FSPS_WAIT) && flash_ack && !flash_prot_err
        && is_blank && flash_rdata != FSPS_ERASED
        || (state_q == FSPS_RUN) && !legal;
    assign wep_set = (state_q == FSPS_WAIT) && flash_ack && flash_prot_err;

    always_ff @(posedge sys_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            state_q <= FSPS_IDLE;
            cpu_halted_q <= 1'b0;
            cur_q <= FSPS_ZERO8;
            flash_req_q <= 1'b0;
            flash_we_q <= 1'b0;
            flash_erase_q <= 1'b0;
            flash_addr_q <= 16'h0000;
            flash_wdata_q <= FSPS_ZERO8;
        end
        else if (clk_en)
        begin
            case (state_q)
                FSPS_IDLE:
                    if (wr && wa == FSPS_OFF_HALT && self_prog_mode_q
                        && (is_erase || is_blank || is_write))
                    begin
                        state_q <= FSPS_RUN;
                        cpu_halted_q <= 1'b1;
                        cur_q <= apl_q;
                    end
                FSPS_RUN:
                    if (!legal)
                        state_q <= FSPS_DONE;
                    else
                    begin
                        flash_req_q <= 1'b1;
                        flash_addr_q <= {aph_q, cur_q};
                        flash_we_q <= is_write;
                        flash_erase_q <= is_erase;
                        flash_wdata_q <= wbuf_q;
                        state_q <= FSPS_WAIT;
                    end
                FSPS_WAIT:
                    if (flash_ack)
                    begin
                        flash_req_q <= 1'b0;
                        flash_we_q <= 1'b0;
                        flash_erase_q <= 1'b0;
                        state_q <= FSPS_NEXT;
                    end
                FSPS_NEXT:
                    // Blank check steps byte by byte up to the low compare
                    if (is_blank && cur_q != aplc_q && stat_q == 3'h0)
                    begin
                        cur_q <= cur_q + 1'b1;
                        state_q <= FSPS_RUN;
                    end
                    else
                        state_q <= FSPS_DONE;
                FSPS_DONE:
                begin
                    cpu_halted_q <= 1'b0;
                    state_q <= FSPS_IDLE;
                end
                default: state_q <= FSPS_IDLE;
            endcase
        end
    end
endmodule

// File: testbench/fsps_top_assertions.sv
// Concurrent checks on the sequencer top ports: bus answers, flash handshake.
// Assumes one clock domain, clk_en held high, active-low async reset.
module fsps_top_assertions (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic s_axil_wvalid,
    input wire logic s_axil_wready,
    input wire logic s_axil_bvalid,
    input wire logic s_axil_bready,
    input wire logic s_axil_arvalid,
    input wire logic s_axil_arready,
    input wire logic s_axil_rvalid,
    input wire logic [31:0] s_axil_rdata,
    input wire logic cpu_halted_q,
    input wire logic flash_req_q,
    input wire logic flash_we_q,
    input wire logic flash_erase_q,
    input wire logic [15:0] flash_addr_q,
    input wire logic flash_ack
);
    // ********
    // Properties
    // ********
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    req_hold_a: assert property (flash_req_q && !flash_ack |=> flash_req_q && $stable(flash_addr_q))
        else $error("flash request dropped or moved before ack");
    req_halted_a: assert property (flash_req_q |-> cpu_halted_q)
        else $error("flash access while cpu not halted");
    one_kind_a: assert property (flash_req_q |-> !(flash_we_q && flash_erase_q))
        else $error("program and erase requested together");
    cpu_resume_a: assert property (flash_req_q && flash_ack && (flash_we_q || flash_erase_q)
        |-> ##[1:4] !cpu_halted_q)
        else $error("cpu not released after last access");
    rd_answer_a: assert property (s_axil_arvalid && s_axil_arready |=> s_axil_rvalid)
        else $error("read answer late");
    rd_upper_a: assert property (s_axil_rvalid |-> s_axil_rdata[31:8] == 24'h000000)
        else $error("read upper bits not zero");
    wr_answer_a: assert property (s_axil_wvalid && s_axil_wready |-> ##[1:3] s_axil_bvalid)
        else $error("write answer missing");
    b_single_a: assert property (s_axil_bvalid && s_axil_bready |=> !s_axil_bvalid)
        else $error("write answered twice");
endmodule

bind fsps_top fsps_top_assertions u_chk (.sys_clk(sys_clk), .arst_n(arst_n),
    .s_axil_wvalid(s_axil_wvalid), .s_axil_wready(s_axil_wready),
    .s_axil_bvalid(s_axil_bvalid), .s_axil_bready(s_axil_bready),
    .s_axil_arvalid(s_axil_arvalid), .s_axil_arready(s_axil_arready),
    .s_axil_rvalid(s_axil_rvalid), .s_axil_rdata(s_axil_rdata),
    .cpu_halted_q(cpu_halted_q), .flash_req_q(flash_req_q), .flash_we_q(flash_we_q),
    .flash_erase_q(flash_erase_q), .flash_addr_q(flash_addr_q), .flash_ack(flash_ack));

// File: testbench/fsps_flash_model.sv
// Behavioural flash array: erased bytes read FFh, one block is protected.
// Assumes requests are held until ack; slow selects a longer access.
module fsps_flash_model (
    input wire logic clk,
    input wire logic req,
    input wire logic we,
    input wire logic erase,
    input wire logic [15:0] addr,
    input wire logic [7:0] wdata,
    input wire logic slow,
    input wire logic [7:0] prot_blk,
    output logic ack,
    output logic [7:0] rdata,
    output logic prot_err
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [logic [15:0]];
    int cnt = 0;
    bit ok;

    initial
    begin
        ack = 1'b0;
        rdata = 8'h00;
        prot_err = 1'b0;
    end

    // Read data is only valid with ack, so it toggles otherwise
    always @(posedge clk)
    begin
        ack <= 1'b0;
        prot_err <= 1'b0;
        rdata <= ~rdata;
        cnt = (req && !ack) ? cnt + 1 : 0;
        ok = (addr[15:8] != prot_blk);
        if (cnt > (slow ? 4 : 1))
        begin
            cnt = 0;
            ack <= 1'b1;
            prot_err <= !ok;
            rdata <= mem.exists(addr) ? mem[addr] : 8'hff;
            if (ok && erase)
                for (int i = 0; i < 256; i++) mem.delete({addr[15:8], 8'(i)});
            else if (ok && we)
                mem[addr] = wdata;
        end
    end
endmodule

// File: testbench/tb_fsps_top.sv
// Self-checking bench for the sequencer: unlock, erase, blank check, write.
// Assumes the flash model beside it and a mirror of the array kept here.
module tb_fsps_top
    import fsps_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [1:0] OK = FSPS_RESP_OKAY;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, f_wd, f_rd, prot_blk = 8'h03;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, halted, mode, f_req, f_we, f_er;
    logic f_ack, f_perr, wdo, slow = 1'b0;
    logic [1:0] bresp, rresp;
    logic [15:0] f_addr;
    int mismatches = 0, checks_done = 0, seed = 51, sticky = 0;
    int tmem [int];

    always #50 sys_clk = ~sys_clk;

    fsps_top #(.WDT_LIMIT(20)) u_dut (.sys_clk(sys_clk), .arst_n(arst_n), .clk_en(1'b1),
        .s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid), .s_axil_awready(awready),
        .s_axil_wdata(wdata), .s_axil_wstrb(wstrb), .s_axil_wvalid(wvalid),
        .s_axil_wready(wready), .s_axil_bresp(bresp), .s_axil_bvalid(bvalid),
        .s_axil_bready(bready), .s_axil_araddr(araddr), .s_axil_arvalid(arvalid),
        .s_axil_arready(arready), .s_axil_rdata(rdata), .s_axil_rresp(rresp),
        .s_axil_rvalid(rvalid), .s_axil_rready(rready), .cpu_halted_q(halted),
        .self_prog_mode_q(mode), .wdt_overflow_q(wdo), .flash_req_q(f_req), .flash_we_q(f_we),
        .flash_erase_q(f_er), .flash_addr_q(f_addr), .flash_wdata_q(f_wd),
        .flash_ack(f_ack), .flash_rdata(f_rd), .flash_prot_err(f_perr));

    fsps_flash_model u_flash (.clk(sys_clk), .req(f_req), .we(f_we), .erase(f_er),
        .addr(f_addr), .wdata(f_wd), .slow(slow), .prot_blk(prot_blk), .ack(f_ack),
        .rdata(f_rd), .prot_err(f_perr));

    // ********
    // Bus tasks and checks
    // ********
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic axw(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever
        begin
            @(posedge sys_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        chk("bresp", 32'(bresp), 32'(er));
    endtask

    task automatic axr(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever
        begin
            @(posedge sys_clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        d = rdata;
        chk("rresp", 32'(rresp), 32'(er));
    endtask

    // Mirror of the array: returns the status bits an operation should set
    function automatic int model_op(input logic [7:0] c, h, l, hc, lc, wb);
        if (c == FSPS_CMD_WRITE)
        begin
            if (h == prot_blk) return 4;
            tmem[h * 256 + l] = wb;
            return 0;
        end
        if (hc != h || l != 8'h00 || lc != (c == FSPS_CMD_BLANK ? 8'hff : 8'h00)) return 2;
        if (h == prot_blk) return 4;
        for (int i = 0; i < 256; i++)
            if (c == FSPS_CMD_ERASE) tmem.delete(h * 256 + i);
            else if (tmem.exists(h * 256 + i)) return 2;
        return 0;
    endfunction

    task automatic op(input logic [7:0] c, h, l, hc, lc, wb, input bit clr);
        int n;
        n = model_op(c, h, l, hc, lc, wb);
        sticky = clr ? n : (sticky | n);
        slow <= 1'($random(seed));
        axw(FSPS_OFF_CMD, c, OK);
        axw(FSPS_OFF_APH, h, OK);
        axw(FSPS_OFF_APL, l, OK);
        axw(FSPS_OFF_APHC, hc, OK);
        axw(FSPS_OFF_APLC, lc, OK);
        axw(FSPS_OFF_WBUF, wb, OK);
        if (clr) axw(FSPS_OFF_STAT, 8'h00, OK);
        if (clr) axw(FSPS_OFF_WATCHDOG_ENABLE_REG, FSPS_WDT_KEY, OK);
        axw(FSPS_OFF_HALT, 8'h01, OK);
        // Lands mid-run for real operations; must leave the target alone
        axw(FSPS_OFF_APH, 8'h55, OK);
        for (n = 0; halted && n < 4000; n++) @(posedge sys_clk);
        chk("cpu halted", 32'(halted), 32'h0);
        axr(FSPS_OFF_STAT, rd, OK);
        chk("status", rd, 32'(sticky));
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ********
    // Main sequence
    // ********
    initial
    begin
        logic [7:0] ba, bd;
        repeat (2) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        axr(FSPS_OFF_STAT, rd, OK);
        chk("status reset", rd, 32'h0);
        axr(8'h30, rd, FSPS_RESP_SLVERR);
        chk("unmapped read", rd, 32'h0);
        axw(FSPS_OFF_MODE, 8'h01, OK);
        axr(FSPS_OFF_STAT, rd, OK);
        chk("sequence error", rd, 32'h1);
        axr(FSPS_OFF_MODE, rd, OK);
        chk("mode kept", rd, 32'h0);
        axw(FSPS_OFF_STAT, 8'h00, OK);
        axw(FSPS_OFF_PROT, FSPS_PROT_KEY, OK);
        axw(FSPS_OFF_MODE, 8'h01, OK);
        axw(FSPS_OFF_MODE, 8'hfe, OK);
        axw(FSPS_OFF_MODE, 8'h01, OK);
        chk("mode pin", 32'(mode), 32'h1);
        axr(FSPS_OFF_STAT, rd, OK);
        chk("unlock status", rd, 32'h0);
        ba = 8'($random(seed));
        bd = 8'($random(seed)) & 8'hfe;
        op(FSPS_CMD_ERASE, 8'h07, 8'h00, 8'h07, 8'h00, 8'h00, 1'b1);
        op(FSPS_CMD_ERASE, 8'h07, 8'h00, 8'h07, 8'h01, 8'h00, 1'b1);
        op(FSPS_CMD_BLANK, 8'h07, 8'h00, 8'h07, 8'hff, 8'h00, 1'b1);
        op(FSPS_CMD_WRITE, 8'h07, ba, 8'h00, 8'h00, bd, 1'b1);
        chk("array byte", 32'(u_flash.mem[{8'h07, ba}]), 32'(bd));
        op(FSPS_CMD_BLANK, 8'h07, 8'h00, 8'h07, 8'hff, 8'h00, 1'b1);
        op(FSPS_CMD_WRITE, 8'h03, ba, 8'h00, 8'h00, bd, 1'b1);
        prot_blk = 8'h0f;
        op(FSPS_CMD_ERASE, 8'h03, 8'h00, 8'h03, 8'h00, 8'h00, 1'b1);
        op(FSPS_CMD_WRITE, 8'h03, ba, 8'h00, 8'h00, bd, 1'b1);
        op(FSPS_CMD_ERASE, 8'h0f, 8'h00, 8'h0f, 8'h00, 8'h00, 1'b1);
        op(FSPS_CMD_ERASE, 8'h07, 8'h00, 8'h07, 8'h00, 8'h00, 1'b0);
        op(FSPS_CMD_BLANK, 8'h07, 8'h00, 8'h07, 8'hff, 8'h00, 1'b1);
        chk("watchdog overflow", 32'(wdo), 32'h1);
        axw(FSPS_OFF_WATCHDOG_ENABLE_REG, FSPS_WDT_KEY, OK);
        chk("watchdog cleared", 32'(wdo), 32'h0);
        axr(FSPS_OFF_WDCNT, rd, OK);
        chk("watchdog restart", 32'(rd < 32'h8), 32'h1);
        tally_and_finish;
    end

    initial
    begin
        repeat (40000) @(posedge sys_clk);
        mismatches++;
        tally_and_finish;
    end
endmodule
